// ---- logic/rvc_top.sv ----
// Rail voltage code control with AXI4-Lite register access
`timescale 1ns/1ps
module rvc_top #(
  parameter int unsigned POLL = rvc_pkg::POLL_CYCLES,
  parameter int unsigned MSC  = rvc_pkg::MS_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [15:0] CODE_PINS,
  input  wire logic [3:0]  RAIL_RAMPING,
  input  wire logic [3:0]  RAIL_RAMP_TOP,
  input  wire logic        RESTORE_DEFAULTS,
  output logic [63:0]      VREF,
  output logic [3:0]       CODE_LOCKED
);
  import rvc_pkg::*;
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  st_wsel_q, st_init_q;
  logic [15:0] st_low_q, st_high_q, st_lock_q;
  logic [3:0]  st_len_q;
  logic [1:0]  rail_sel_q;
  logic [7:0]  wsel_q [N_RAIL];
  logic [7:0]  init_q [N_RAIL];
  logic [15:0] low_q  [N_RAIL];
  logic [15:0] high_q [N_RAIL];
  logic [15:0] lock_q [N_RAIL];
  logic [7:0]  code_wr_q [N_RAIL];
  logic [1:0]  oper_q;
  logic [15:0] vnom_q, vmhi_q, vmlo_q;
  logic        refused_q;
  logic [3:0]  load_q;
  logic [7:0]  code_act [N_RAIL];
  logic [15:0] vref_r [N_RAIL];
  logic        aw_q, w_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_q && !bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  wire        aw_hs  = S_AXI_AWVALID && S_AXI_AWREADY;
  wire        w_hs   = S_AXI_WVALID && S_AXI_WREADY;
  wire        aw_now = aw_q || aw_hs;
  wire        w_now  = w_q || w_hs;
  wire [7:0]  wa     = aw_q ? awaddr_q : S_AXI_AWADDR;
  wire [31:0] wd     = w_q ? wdata_q : S_AXI_WDATA;
  wire        do_wr  = aw_now && w_now && !bvalid_q;
  wire        full   = &S_AXI_WSTRB;
  wire        wr_map = (wa[1:0] == 2'b00) && (wa <= OFS_RAIL_SEL);
  wire        wr_commit = do_wr && wa == OFS_COMMIT;

  // Setup validity
  wire wsel_ok = st_wsel_q == WSEL_OFF || st_wsel_q == WSEL_PAR4
              || st_wsel_q == WSEL_SER6 || st_wsel_q == WSEL_BUS8
              || ((st_wsel_q == WSEL_PAR7 || st_wsel_q == WSEL_PAR8)
                  && !rail_sel_q[0]);
  wire [7:0] init_max = (st_wsel_q == WSEL_PAR4) ? 8'h0F
                      : (st_wsel_q == WSEL_SER6) ? 8'h3F
                      : (st_wsel_q == WSEL_PAR7) ? 8'h7F : 8'hFF;
  wire init_ok = st_wsel_q == WSEL_OFF || st_init_q <= init_max;
  wire len_ok  = st_len_q == LEN_A || st_len_q == LEN_B
              || st_len_q == LEN_C || st_len_q == LEN_D;
  wire setup_ok = wsel_ok && init_ok && len_ok;
  wire apply    = wr_commit && wd[7:0] == CMD_SETUP && setup_ok;
  wire wr_err   = do_wr && (!wr_map || (wr_commit && !(wd[7:0] == CMD_SETUP && setup_ok)));

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
    end else begin
      if (aw_hs) awaddr_q <= S_AXI_AWADDR;
      if (w_hs)  wdata_q  <= S_AXI_WDATA;
      aw_q <= do_wr ? 1'b0 : aw_now;
      w_q  <= do_wr ? 1'b0 : w_now;
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_BREADY) bvalid_q <= 1'b0;
    end
  end

  // Staging and control registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_wsel_q  <= RST_WSEL;
      st_init_q  <= RST_INIT;
      st_low_q   <= RST_ENDPOINT;
      st_high_q  <= RST_ENDPOINT;
      st_lock_q  <= RST_LOCKOUT;
      st_len_q   <= LEN_D;
      rail_sel_q <= 2'b00;
      oper_q     <= 2'b00;
      vnom_q     <= RST_ENDPOINT;
      vmhi_q     <= RST_ENDPOINT;
      vmlo_q     <= RST_ENDPOINT;
    end else if (do_wr && full) begin
      unique case (wa)
        OFS_SETUP0: begin
          st_wsel_q <= wd[7:0];
          st_init_q <= wd[15:8];
        end
        OFS_SETUP1: begin
          st_low_q  <= wd[15:0];
          st_high_q <= wd[31:16];
        end
        OFS_SETUP2: begin
          st_lock_q <= wd[15:0];
          st_len_q  <= wd[19:16];
        end
        OFS_OPER:     oper_q     <= wd[1:0];
        OFS_VNOM:     vnom_q     <= wd[15:0];
        OFS_VMARG: begin
          vmlo_q <= wd[15:0];
          vmhi_q <= wd[31:16];
        end
        OFS_RAIL_SEL: rail_sel_q <= wd[1:0];
        default: ;
      endcase
    end
  end

  // Committed per-rail setup; short lengths leave trailing fields
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      for (int i = 0; i < N_RAIL; i++) begin
        wsel_q[i]    <= RST_WSEL;
        init_q[i]    <= RST_INIT;
        low_q[i]     <= RST_ENDPOINT;
        high_q[i]    <= RST_ENDPOINT;
        lock_q[i]    <= RST_LOCKOUT;
        code_wr_q[i] <= RST_CODE_WR;
      end
    end else begin
      if (RESTORE_DEFAULTS) begin
        for (int i = 0; i < N_RAIL; i++) begin
          wsel_q[i] <= RST_WSEL;
          init_q[i] <= RST_INIT;
          low_q[i]  <= RST_ENDPOINT;
          high_q[i] <= RST_ENDPOINT;
          lock_q[i] <= RST_LOCKOUT;
        end
      end else if (apply) begin
        wsel_q[rail_sel_q] <= st_wsel_q;
        low_q[rail_sel_q]  <= st_low_q;
        high_q[rail_sel_q] <= st_high_q;
        if (st_len_q >= LEN_B) init_q[rail_sel_q] <= st_init_q;
        if (st_len_q == LEN_D) lock_q[rail_sel_q] <= st_lock_q;
      end
      if (do_wr && wa == OFS_CODE_WR) begin
        for (int i = 0; i < N_RAIL; i++)
          if (S_AXI_WSTRB[i]) code_wr_q[i] <= wd[8*i +: 8];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      load_q    <= 4'hF;
      refused_q <= 1'b0;
    end else begin
      load_q <= RESTORE_DEFAULTS ? 4'hF : 4'h0;
      if (wr_commit) refused_q <= !(wd[7:0] == CMD_SETUP && setup_ok);
    end
  end

  // ---------------------------------------------------------------
  // Rails
  // ---------------------------------------------------------------
  wire [15:0] v_oper = (oper_q == 2'b01) ? vmhi_q
                     : (oper_q == 2'b10) ? vmlo_q : vnom_q;
  for (genvar r = 0; r < N_RAIL; r++) begin : g_rail
    localparam int unsigned NX = (r + 1) % N_RAIL;
    localparam int unsigned PV = (r + N_RAIL - 1) % N_RAIL;
    wire barred = (r % 2 == 1)
               && (wsel_q[PV] == WSEL_PAR7 || wsel_q[PV] == WSEL_PAR8);
    rvc_rail #(.POLL(POLL), .MSC(MSC)) u_rail (
      .clk        (CLK_SYS),
      .rst_n      (RESETN),
      .load_init  (load_q[r]),
      .wsel       (wsel_q[r]),
      .v_low      (low_q[r]),
      .v_high     (high_q[r]),
      .init_code  (init_q[r]),
      .lockout    (lock_q[r]),
      .own_pins   (CODE_PINS[4*r +: 4]),
      .next_pins  (CODE_PINS[4*NX +: 4]),
      .pins_barred(barred),
      .bus_code   (code_wr_q[r]),
      .ramping    (RAIL_RAMPING[r]),
      .ramp_top   (RAIL_RAMP_TOP[r]),
      .v_oper     (v_oper),
      .code_q     (code_act[r]),
      .vref_q     (vref_r[r]),
      .locked     (CODE_LOCKED[r])
    );
    assign VREF[16*r +: 16] = vref_r[r];
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  wire [7:0]  ra    = S_AXI_ARADDR;
  wire [1:0]  ridx  = 2'(ra[3:2] - 2'b10);
  wire        r_vref = ra >= OFS_VREF_BASE && ra < OFS_VREF_BASE + 8'h10;
  wire        r_ok  = ra[1:0] == 2'b00 && (ra <= OFS_RAIL_SEL || r_vref);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ra)
      OFS_SETUP0:   rd_mux = {16'h0000, init_q[rail_sel_q], wsel_q[rail_sel_q]};
      OFS_SETUP1:   rd_mux = {high_q[rail_sel_q], low_q[rail_sel_q]};
      OFS_SETUP2:   rd_mux = {12'h000, st_len_q, lock_q[rail_sel_q]};
      OFS_CODE_WR:  rd_mux = {code_wr_q[3], code_wr_q[2], code_wr_q[1], code_wr_q[0]};
      OFS_STATUS:   rd_mux = {19'h00000, refused_q, CODE_LOCKED, code_act[rail_sel_q]};
      OFS_OPER:     rd_mux = {30'h00000000, oper_q};
      OFS_VNOM:     rd_mux = {16'h0000, vnom_q};
      OFS_VMARG:    rd_mux = {vmhi_q, vmlo_q};
      OFS_RAIL_SEL: rd_mux = {30'h00000000, rail_sel_q};
      default:      rd_mux = (r_ok && r_vref) ? {16'h0000, vref_r[ridx]} : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= r_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) rvalid_q <= 1'b0;
  end
endmodule : rvc_top

// ---- logic/rvc_pkg.sv ----
// Constants for the rail voltage code block
package rvc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;
  localparam int unsigned POLL_CYCLES    = 200;
  // ---------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SETUP0     = 8'h00; // width, init code
  localparam logic [7:0] OFS_SETUP1     = 8'h04; // low/high endpoint
  localparam logic [7:0] OFS_SETUP2     = 8'h08; // lockout, length
  localparam logic [7:0] OFS_COMMIT     = 8'h0C; // write applies setup
  localparam logic [7:0] OFS_CODE_WR    = 8'h10; // four rail codes
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_OPER       = 8'h18; // operation, voltages sel
  localparam logic [7:0] OFS_VNOM       = 8'h1C;
  localparam logic [7:0] OFS_VMARG      = 8'h20; // hi[31:16] lo[15:0]
  localparam logic [7:0] OFS_RAIL_SEL   = 8'h24;
  localparam logic [7:0] OFS_VREF_BASE  = 8'h28; // 4 words
  // ---------------------------------------------------------------
  // Commands and widths
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SETUP      = 8'hBB;
  localparam logic [7:0] CMD_CODE_BASE  = 8'hBC;
  localparam logic [7:0] WSEL_OFF       = 8'h00;
  localparam logic [7:0] WSEL_PAR4      = 8'h04;
  localparam logic [7:0] WSEL_SER6      = 8'h06;
  localparam logic [7:0] WSEL_PAR7      = 8'h07;
  localparam logic [7:0] WSEL_BUS8      = 8'h08;
  localparam logic [7:0] WSEL_PAR8      = 8'h18;
  localparam logic [3:0] LEN_A          = 4'h5;
  localparam logic [3:0] LEN_B          = 4'h6;
  localparam logic [3:0] LEN_C          = 4'h7;
  localparam logic [3:0] LEN_D          = 4'h9;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_WSEL      = 8'h00;
  localparam logic [15:0] RST_ENDPOINT  = 16'h0000;
  localparam logic [7:0]  RST_INIT      = 8'h00;
  localparam logic [15:0] RST_LOCKOUT   = 16'h0000;
  localparam logic [7:0]  RST_CODE_WR   = 8'hFF;
  localparam int unsigned N_RAIL        = 4;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage : rvc_pkg

// ---- logic/rvc_rail.sv ----
// One rail: code capture, lockout timer and reference arithmetic
`timescale 1ns/1ps
module rvc_rail #(
  parameter int unsigned POLL = rvc_pkg::POLL_CYCLES,
  parameter int unsigned MSC  = rvc_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load_init,
  input  wire logic [7:0]  wsel,
  input  wire logic [15:0] v_low,
  input  wire logic [15:0] v_high,
  input  wire logic [7:0]  init_code,
  input  wire logic [15:0] lockout,
  input  wire logic [3:0]  own_pins,
  input  wire logic [3:0]  next_pins,
  input  wire logic        pins_barred,
  input  wire logic [7:0]  bus_code,
  input  wire logic        ramping,
  input  wire logic        ramp_top,
  input  wire logic [15:0] v_oper,
  output logic      [7:0]  code_q,
  output logic      [15:0] vref_q,
  output logic             locked
);
  import rvc_pkg::*;
  logic [15:0] poll_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [14:0] lock_ms_q;
  logic        lock_q;
  logic        strobe_q;
  logic [7:0]  code_d;
  logic [7:0]  maxc;
  logic [31:0] prod;
  logic [15:0] vref_d;
  wire         poll_tick = (poll_cnt_q == 16'(POLL - 1));
  wire         no_lock   = lockout[15];
  wire         pins_ok   = !pins_barred && !(locked);
  wire         strobe_ev = own_pins[3] != strobe_q;

  // ---------------------------------------------------------------
  // Lockout
  // ---------------------------------------------------------------
  // Top pulse keeps the lock until the timer has loaded
  assign locked = !no_lock && (ramping || lock_q || (ramp_top && lockout != 16'h0000));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_q    <= 1'b0;
      lock_ms_q <= '0;
      ms_cnt_q  <= '0;
    end else if (ramp_top && lockout != 16'h0000 && !no_lock) begin
      lock_q    <= 1'b1;
      lock_ms_q <= lockout[14:0];
      ms_cnt_q  <= '0;
    end else if (lock_q) begin
      ms_cnt_q <= (ms_cnt_q == 16'(MSC - 1)) ? '0 : ms_cnt_q + 16'h0001;
      if (ms_cnt_q == 16'(MSC - 1)) begin
        lock_ms_q <= lock_ms_q - 15'h0001;
        if (lock_ms_q == 15'h0001) lock_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Code capture
  // ---------------------------------------------------------------
  always_comb begin
    code_d = code_q;
    unique case (wsel)
      WSEL_PAR4: if (poll_tick && pins_ok) code_d = {4'h0, own_pins};
      WSEL_SER6: if (strobe_ev && pins_ok) begin
        if (own_pins[3]) code_d = {2'b00, own_pins[2:0], code_q[2:0]};
        else code_d = {2'b00, code_q[5:3], own_pins[2:0]};
      end
      WSEL_PAR7: if (poll_tick && pins_ok) code_d = {1'b0, next_pins[2:0], own_pins};
      WSEL_PAR8: if (poll_tick && pins_ok) code_d = {next_pins, own_pins};
      WSEL_BUS8: code_d = bus_code;
      default:   code_d = code_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poll_cnt_q <= '0;
      strobe_q   <= 1'b0;
      code_q     <= RST_INIT;
    end else begin
      poll_cnt_q <= poll_tick ? '0 : poll_cnt_q + 16'h0001;
      strobe_q   <= own_pins[3];
      code_q     <= load_init ? init_code : code_d;
    end
  end

  // ---------------------------------------------------------------
  // Reference
  // ---------------------------------------------------------------
  always_comb begin
    unique case (wsel)
      WSEL_PAR4: maxc = 8'h0F;
      WSEL_SER6: maxc = 8'h3F;
      WSEL_PAR7: maxc = 8'h7F;
      default:   maxc = 8'hFF;
    endcase
    prod   = 32'(code_q) * 32'(v_high - v_low);
    vref_d = (wsel == WSEL_OFF) ? v_oper
           : 16'(prod / 32'(maxc)) + v_low;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) vref_q <= RST_ENDPOINT;
    else        vref_q <= vref_d;
  end
endmodule : rvc_rail

// ---- sim/rvc_assertions.sv ----
// Port assertions for the rail voltage code block
`timescale 1ns/1ps
module rvc_checker
  import rvc_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [3:0]  RAIL_RAMPING,
  input wire logic [63:0] VREF,
  input wire logic [3:0]  CODE_LOCKED
);
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  property p_vref_reset;
    $rose(RESETN) |-> VREF == 64'h0;
  endproperty
  a_vref_reset: assert property (p_vref_reset) else $error("reference not zero at reset");

  // Lock may only drop once the ramp has ended
  property p_unlock_ramp;
    ($past(CODE_LOCKED) & ~CODE_LOCKED & RAIL_RAMPING) == 4'h0;
  endproperty
  a_unlock_ramp: assert property (p_unlock_ramp) else $error("lock released mid ramp");

  property p_b_after_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID;
  endproperty
  a_b_after_wr: assert property (p_b_after_wr) else $error("write response late");

  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");

  property p_busy_ready;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_busy_ready: assert property (p_busy_ready) else $error("write taken while busy");

  property p_r_after_ar;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");

  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  property p_err_zero;
    S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");

  c_refused: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
  c_unlock: cover property ($fell(CODE_LOCKED[2]));
  c_r_stall: cover property (S_AXI_RVALID && !S_AXI_RREADY);
endmodule : rvc_checker

bind rvc_top rvc_checker u_chk (.*);

// ---- sim/rvc_pin_src.sv ----
// Code pin source and soft-start ramp model
`timescale 1ns/1ps
module rvc_pin_src (
  input  wire logic        clk,
  output logic      [15:0] pins,
  output logic      [3:0]  ramping,
  output logic      [3:0]  ramp_top
);
  initial begin
    pins     = 16'h0000;
    ramping  = 4'h0;
    ramp_top = 4'h0;
  end
  task automatic put(input int r, input logic [3:0] v);
    @(posedge clk);
    pins[4*r +: 4] <= v;
  endtask : put
  // Upper half on rising strobe, lower half on falling
  task automatic ser6(input int r, input logic [5:0] c);
    @(posedge clk);
    pins[4*r +: 3] <= c[5:3];
    repeat (3) @(posedge clk);
    pins[4*r+3] <= 1'h1;
    repeat (3) @(posedge clk);
    pins[4*r +: 3] <= c[2:0];
    repeat (3) @(posedge clk);
    pins[4*r+3] <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : ser6
  // Ramp end gives a one-cycle top pulse
  task automatic ramp(input int r, input logic on);
    @(posedge clk);
    ramping[r]  <= on;
    ramp_top[r] <= !on;
    @(posedge clk);
    ramp_top[r] <= 1'h0;
  endtask : ramp
endmodule : rvc_pin_src

// ---- sim/tb_top.sv ----
// Self-checking bench for the rail voltage code block
`timescale 1ns/1ps
module tb_top;
  import rvc_pkg::*;
  localparam int unsigned POLL_T = 4;
  localparam int unsigned MSC_T  = 10;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rvc_exp_s;
  logic        clk = '0;
  logic        rst_n = '0;
  logic        restore = '0;
  logic [7:0]  awaddr = '0;
  logic [7:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pins;
  logic [3:0]  ramping, ramp_top, locked;
  logic [63:0] vref;
  logic [3:0]  lens [3] = '{LEN_A, LEN_B, LEN_C};
  int          num_errors = 0;
  int          n_checks = 0;
  rvc_exp_s    rq[$];
  rvc_exp_s    ex;
  logic [1:0]  wq[$];

  always #25 clk = ~clk;

  rvc_pin_src pin (.clk(clk), .pins(pins), .ramping(ramping), .ramp_top(ramp_top));
  rvc_top #(.POLL(POLL_T), .MSC(MSC_T)) uut (
    .CLK_SYS(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CODE_PINS(pins), .RAIL_RAMPING(ramping), .RAIL_RAMP_TOP(ramp_top),
    .RESTORE_DEFAULTS(restore), .VREF(vref), .CODE_LOCKED(locked)
  );

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic final_report();
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Write with one stall cycle before the response is accepted
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] e);
    logic ad;
    logic dd;
    ad = '0;
    dd = '0;
    wq.push_back(e);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= '1;
    wvalid  <= '1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready === 1'h1 && !ad) awvalid <= '0;
      if (wready === 1'h1 && !dd) wvalid <= '0;
      ad = ad | (awready === 1'h1);
      dd = dd | (wready === 1'h1);
    end
    @(posedge clk);
    bready <= '1;
    do @(posedge clk); while (bvalid !== 1'h1);
    bready <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] e);
    rq.push_back('{d, m, e});
    araddr  <= a;
    arvalid <= '1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= '0;
    @(posedge clk);
    rready  <= '1;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready  <= '0;
    @(posedge clk);
  endtask : rd

  task automatic vr(input int r, input logic [15:0] v);
    rd(OFS_VREF_BASE + 8'(4 * r), {16'h0, v}, 32'h0000_FFFF, RESP_OKAY);
    cmp("vref_pin", {16'h0, v}, {16'h0, vref[16*r +: 16]});
  endtask : vr

  task automatic setup(input int r, input logic [7:0] w, input logic [7:0] ic,
                       input logic [31:0] lohi, input logic [15:0] lk, input logic [3:0] ln,
                       input logic [1:0] e);
    wr(OFS_RAIL_SEL, 32'(r), 4'hF, RESP_OKAY);
    wr(OFS_SETUP0, {16'h0, ic, w}, 4'hF, RESP_OKAY);
    wr(OFS_SETUP1, lohi, 4'hF, RESP_OKAY);
    wr(OFS_SETUP2, {12'h0, ln, lk}, 4'hF, RESP_OKAY);
    wr(OFS_COMMIT, {24'h0, CMD_SETUP}, 4'hF, e);
  endtask : setup

  // Response monitor pairs each answer with the oldest note
  always @(posedge clk) begin
    if (bvalid === 1'h1 && bready === 1'h1 && wq.size() > 0)
      cmp("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
    if (rvalid === 1'h1 && rready === 1'h1 && rq.size() > 0) begin
      ex = rq.pop_front();
      cmp("rresp", {30'h0, ex.r}, {30'h0, rresp});
      cmp("rdata", ex.d & ex.m, rdata & ex.m);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    logic [7:0] c;
    void'($urandom(32'h31B56A53));
    repeat (12) @(posedge clk);
    rst_n <= '1;
    @(posedge clk);
    rd(OFS_SETUP0, 32'h0, 32'h0000_FFFF, RESP_OKAY);
    rd(OFS_SETUP1, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_SETUP2, 32'h0, 32'h0000_FFFF, RESP_OKAY);
    rd(OFS_CODE_WR, 32'hFFFF_FFFF, 32'hFFFF_FFFF, RESP_OKAY);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_VNOM, 32'h0000_1234, 4'hF, RESP_OKAY);
    wr(OFS_VMARG, 32'h2000_0800, 4'hF, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_OPER, 32'(i), 4'hF, RESP_OKAY);
      vr(0, i == 0 ? 16'h1234 : i == 1 ? 16'h2000 : 16'h0800);
    end
    c = 8'($urandom);
    wr(OFS_CODE_WR, {24'h0, c}, 4'h1, RESP_OKAY);
    vr(0, 16'h0800);
    setup(0, WSEL_BUS8, 8'h00, 32'h1FF0_1000, 16'h8000, LEN_D, RESP_OKAY);
    vr(0, 16'h1000 + 16'(c) * 16'h0010);
    pin.put(0, 4'($urandom));
    repeat (3 * POLL_T) @(posedge clk);
    vr(0, 16'h1000 + 16'(c) * 16'h0010);
    wr(OFS_CODE_WR, 32'h2200_0000, 4'h8, RESP_OKAY);
    rd(OFS_CODE_WR, {8'h22, 16'hFFFF, c}, 32'hFFFF_FFFF, RESP_OKAY);
    wr(OFS_COMMIT, 32'h0000_00BA, 4'hF, RESP_SLVERR);
    setup(1, 8'h05, 8'h00, 32'h0, 16'h0, LEN_D, RESP_SLVERR);
    setup(1, WSEL_PAR4, 8'h10, 32'h0, 16'h0, LEN_D, RESP_SLVERR);
    setup(1, WSEL_PAR4, 8'h00, 32'h0, 16'h0, 4'h8, RESP_SLVERR);
    setup(1, WSEL_PAR8, 8'h00, 32'h0, 16'h0, LEN_D, RESP_SLVERR);
    setup(1, WSEL_PAR7, 8'h00, 32'h0, 16'h0, LEN_D, RESP_SLVERR);
    setup(1, WSEL_OFF, 8'hC8, 32'h0, 16'h0, LEN_D, RESP_OKAY);
    foreach (lens[k]) setup(1, WSEL_OFF, 8'h00, 32'h0, 16'h0, lens[k], RESP_OKAY);
    setup(1, WSEL_PAR4, 8'h00, 32'h003C_0000, 16'h8000, LEN_D, RESP_OKAY);
    pin.ramp(1, '1);
    c = 8'($urandom);
    pin.put(1, c[3:0]);
    repeat (3 * POLL_T) @(posedge clk);
    vr(1, 16'(c[3:0]) * 16'h0004);
    pin.ramp(1, '0);
    setup(3, WSEL_SER6, 8'h00, 32'h007E_0000, 16'h8000, LEN_D, RESP_OKAY);
    c = 8'($urandom);
    pin.ser6(3, c[5:0]);
    vr(3, 16'(c[5:0]) * 16'h0002);
    pin.ramp(2, '1);
    setup(2, WSEL_PAR4, 8'h00, 32'h000F_0000, 16'h0002, LEN_D, RESP_OKAY);
    pin.put(2, 4'h9);
    repeat (3 * POLL_T) @(posedge clk);
    vr(2, 16'h0000);
    rd(OFS_STATUS, 32'h0000_0400, 32'h0000_1FFF, RESP_OKAY);
    cmp("locked", 32'h0000_0004, {28'h0, locked});
    pin.ramp(2, '0);
    vr(2, 16'h0000);
    repeat (2 * MSC_T + 3 * POLL_T) @(posedge clk);
    vr(2, 16'h0009);
    pin.put(1, 4'h3);
    repeat (3 * POLL_T) @(posedge clk);
    vr(1, 16'h000C);
    setup(0, WSEL_PAR7, 8'h00, 32'h007F_0000, 16'h8000, LEN_D, RESP_OKAY);
    pin.put(0, 4'h5);
    pin.put(1, 4'hA);
    repeat (3 * POLL_T) @(posedge clk);
    vr(0, 16'h0025);
    vr(1, 16'h000C);
    restore <= '1;
    @(posedge clk);
    restore <= '0;
    rd(OFS_SETUP0, 32'h0, 32'h0000_FFFF, RESP_OKAY);
    final_report();
  end
endmodule : tb_top
